//--- hw/oms_mode_select.sv
// Start-up operating mode selector with AXI4-Lite control registers
// Functional notes
// - Mode 0: oscillator in, PLL A, drive PLL input
// - Mode 1: as mode 0, ninety degree shift
// - Mode 2: PLL B multiply, drive internal clock
// - Mode 3: PLL B multiply, clock pin undriven
// - Mode 4: clock pin in, PLL A in phase
// - Mode 5: clock pin in, PLL A shifted
// - Mode 6: run from clock pin, PLL A off
// - Bit five role; refuse master if pin high
// - Configuration source takes all six stored bits
// - User source takes all six mode pins
// - Mixed source: pin five role, rest stored
// - Configuration source ignores all-high mode pins
// - Source select defaults to configuration
// - Slave runs only with master's bus grant
// - Grant enabled: drive idle and executing
// - Grant middle: drive only while executing
// - Grant disabled: never drive
// - Trace control gates recording of hit cycles
// - Probe break stops both pods together
// - Mode pins readable without side effects
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module oms_mode_select
  import oms_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock, reset, enable
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_clk_en,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic [2:0]        i_s_axi_awprot,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic [2:0]        i_s_axi_arprot,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  // Pins from user board and partner pod
  input  wire logic [5:0]        i_mode_pins,
  input  wire logic              i_probe_break,
  input  wire logic              i_grant_in,
  // Pod state, same clock
  input  wire logic              i_prog_run,
  input  wire logic              i_core_grant,
  input  wire logic              i_bus_cycle,
  input  wire logic              i_cache_hit,
  // Clock generation controls
  output logic                   o_use_clock_io,
  output logic                   o_phase_lock_a_en,
  output logic                   o_phase_lock_a_shift,
  output logic                   o_multiplier_lock_b_en,
  output logic [1:0]             o_multiplier_lock_b_factor,
  output logic                   o_clock_io_pin_oe,
  output logic                   o_clock_io_sel_pll_in,
  // Configuration results
  output logic [1:0]             o_chip_area_zero_width,
  output logic                   o_role_sel,
  output logic                   o_start_refused,
  output logic                   o_mode_bad,
  output logic                   o_run_enable,
  // Grant, trace, break
  output logic                   o_bus_grant_out,
  output logic                   o_trace_record,
  output logic                   o_break_master,
  output logic                   o_break_slave
);

  // Address must reach the status word
  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] pin_meta_r;  // First stage, read by second only
  logic [7:0] pin_sync_r;  // Second stage

  // Two flops on every asynchronous pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else if (i_clk_en) begin
      pin_meta_r <= {i_grant_in, i_probe_break, i_mode_pins};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire [5:0] pins_s     = pin_sync_r[5:0];
  wire       probe_s    = pin_sync_r[6];
  wire       grant_in_s = pin_sync_r[7];

  // ****************************************
  // Registers and state
  // ****************************************
  oms_src_t   src_r;      // mode_source_sel
  oms_gnt_t   gnt_r;      // grant_output_ctrl
  logic       trc_r;      // hit_trace_ctrl
  logic [1:0] mul_r;      // Multiplier factor select
  logic [5:0] cfg_r;      // Stored mode word
  logic [5:0] mode_r;     // Active mode word
  logic       refused_r;
  logic       bad_r;
  logic       run_r;
  logic       grant_r;
  logic       trace_r;
  logic       brk_r;
  oms_state_t state_r;
  logic [1:0] settle_r;   // Settle counter
  logic [6:0] clk_r;      // Registered clock controls

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic              aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic              w_hold_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;

  // Readies drop while frozen so nothing is taken then
  assign o_s_axi_awready = i_clk_en & ~aw_hold_r & ~bvalid_r;
  assign o_s_axi_wready  = i_clk_en & ~w_hold_r & ~bvalid_r;
  wire aw_fire = i_s_axi_awvalid & o_s_axi_awready;
  wire w_fire  = i_s_axi_wvalid & o_s_axi_wready;
  wire aw_have = aw_hold_r | aw_fire;
  wire w_have  = w_hold_r | w_fire;
  wire wr_do   = i_clk_en & aw_have & w_have & ~bvalid_r;
  wire [ADDR_W-1:0] wa  = aw_hold_r ? awaddr_r : i_s_axi_awaddr;
  wire [31:0]       wd  = w_hold_r ? wdata_r : i_s_axi_wdata;
  wire [3:0]        ws  = w_hold_r ? wstrb_r : i_s_axi_wstrb;
  wire [ADDR_W-1:0] waw = {wa[ADDR_W-1:2], 2'b00};
  wire wsel_ctrl = waw == ADDR_W'(OMS_CTRL_OFS);
  wire wsel_cfg  = waw == ADDR_W'(OMS_CFG_OFS);
  wire wsel_stat = waw == ADDR_W'(OMS_STAT_OFS);
  wire wr_ctrl0  = wr_do & wsel_ctrl & ws[0];
  wire wr_init   = wr_do & wsel_ctrl & ws[1] & wd[OMS_INIT_BIT];
  wire wr_cfg    = wr_do & wsel_cfg & ws[0];
  wire wr_ok     = wsel_ctrl | wsel_cfg | wsel_stat;

  // Hold whichever half arrives first, answer after both
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= '0;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= OMS_RESP_OKAY;
    end else if (i_clk_en) begin
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? OMS_RESP_OKAY : OMS_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_hold_r <= 1'b1;
          awaddr_r  <= i_s_axi_awaddr;
        end
        if (w_fire) begin
          w_hold_r <= 1'b1;
          wdata_r  <= i_s_axi_wdata;
          wstrb_r  <= i_s_axi_wstrb;
        end
        if (bvalid_r && i_s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp  = bresp_r;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  assign o_s_axi_arready = i_clk_en & ~rvalid_r;
  wire ar_fire = i_s_axi_arvalid & o_s_axi_arready;
  wire [ADDR_W-1:0] raw = {i_s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire rsel_ctrl = raw == ADDR_W'(OMS_CTRL_OFS);
  wire rsel_cfg  = raw == ADDR_W'(OMS_CFG_OFS);
  wire rsel_stat = raw == ADDR_W'(OMS_STAT_OFS);
  wire [31:0] ctrl_rd = 32'({mul_r, trc_r, gnt_r, src_r});
  wire [31:0] stat_rd = (32'(pins_s) << OMS_PIN_LSB)
                      | (32'(mode_r) << OMS_ACT_LSB)
                      | (32'(refused_r) << OMS_REF_BIT)
                      | (32'(bad_r) << OMS_BAD_BIT)
                      | (32'(run_r) << OMS_RUN_BIT);
  // Status read is pure: pins shown, clock mode untouched
  wire [31:0] rd_mux = rsel_ctrl ? ctrl_rd
                     : rsel_cfg  ? 32'(cfg_r)
                     : rsel_stat ? stat_rd : 32'h0;
  wire rd_ok = rsel_ctrl | rsel_cfg | rsel_stat;

  // One read in flight; data held until taken
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= OMS_RESP_OKAY;
    end else if (i_clk_en) begin
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_ok ? OMS_RESP_OKAY : OMS_RESP_SLVERR;
      end else if (rvalid_r && i_s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata  = rdata_r;
  assign o_s_axi_rresp  = rresp_r;

  // ****************************************
  // Control registers
  // ****************************************
  // Delivered state: configuration source, grant on
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      src_r <= OMS_SRC_CFG;
      gnt_r <= OMS_GNT_EN;
      trc_r <= OMS_TRC_RST;
      mul_r <= OMS_MUL_RST;
      cfg_r <= OMS_CFG_RST;
    end else if (i_clk_en) begin
      if (wr_ctrl0) begin
        src_r <= oms_src_t'(wd[OMS_SRC_LSB +: 2]);
        gnt_r <= oms_gnt_t'(wd[OMS_GNT_LSB +: 2]);
        trc_r <= wd[OMS_TRC_BIT];
        mul_r <= wd[OMS_MUL_LSB +: 2];
      end
      if (wr_cfg) begin
        cfg_r <= wd[5:0];
      end
    end
  end

  // ****************************************
  // Mode word selection
  // ****************************************
  wire pins_all_hi = pins_s == OMS_ALL_HIGH;
  // Mixed: role from pin, the rest stored
  wire [5:0] mix_word = {pins_s[5], cfg_r[4:0]};
  wire [5:0] sel_word = (src_r == OMS_SRC_USER) ? pins_s
                      : (src_r == OMS_SRC_MIX)  ? mix_word
                      : cfg_r;
  // Stored master clashes with a slave pin unless all high
  wire refuse_nxt = (src_r == OMS_SRC_CFG) & ~pins_all_hi
                  & pins_s[5] & ~sel_word[5];
  wire [2:0] clk_mode = sel_word[2:0];
  wire [1:0] width_sel = sel_word[4:3];
  wire load = i_clk_en & (state_r == OMS_ST_LOAD);

  // Clock decode: {use_io, a_en, a_shift, b_en, oe, pll_in, bad}
  logic [6:0] clk_nxt;
  always_comb begin
    case (clk_mode)
      OMS_CLK_M0: clk_nxt = 7'b0100110;
      OMS_CLK_M1: clk_nxt = 7'b0110110;
      OMS_CLK_M2: clk_nxt = 7'b0001100;
      OMS_CLK_M3: clk_nxt = 7'b0001000;
      OMS_CLK_M4: clk_nxt = 7'b1100000;
      OMS_CLK_M5: clk_nxt = 7'b1110000;
      OMS_CLK_M6: clk_nxt = 7'b1000000;
      default:    clk_nxt = 7'b0000001; // Reserved: all off
    endcase
  end

  // ****************************************
  // Initiation sequence
  // ****************************************
  // Wait for pin synchronisers, sample once, then hold
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r   <= OMS_ST_SETTLE;
      settle_r  <= 2'h0;
      mode_r    <= 6'h00;
      clk_r     <= 7'h00;
      refused_r <= 1'b0;
      bad_r     <= 1'b0;
    end else if (i_clk_en) begin
      case (state_r)
        OMS_ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == OMS_SETTLE_CYC - 2'h1) begin
            state_r <= OMS_ST_LOAD;
          end
        end
        OMS_ST_LOAD: begin
          mode_r    <= sel_word;
          clk_r     <= clk_nxt;
          refused_r <= refuse_nxt;
          bad_r     <= clk_nxt[0] | (width_sel == OMS_WID_RSV);
          state_r   <= OMS_ST_RUN;
        end
        OMS_ST_RUN: begin
          // Only a fresh initiation replaces the word
          if (wr_init) begin
            settle_r <= 2'h0;
            state_r  <= OMS_ST_SETTLE;
          end
        end
        default: state_r <= OMS_ST_SETTLE;
      endcase
    end
  end

  assign o_use_clock_io             = clk_r[6];
  assign o_phase_lock_a_en          = clk_r[5];
  assign o_phase_lock_a_shift       = clk_r[4];
  assign o_multiplier_lock_b_en     = clk_r[3];
  assign o_clock_io_pin_oe          = clk_r[2];
  assign o_clock_io_sel_pll_in      = clk_r[1];
  assign o_multiplier_lock_b_factor = mul_r;
  assign o_chip_area_zero_width     = mode_r[4:3];
  assign o_role_sel                 = mode_r[5];
  assign o_start_refused            = refused_r;
  assign o_mode_bad                 = bad_r;

  // ****************************************
  // Run, grant, trace and break
  // ****************************************
  wire running  = state_r == OMS_ST_RUN;
  // Slave waits on the partner's grant; master on no refusal
  wire run_nxt  = running & (mode_r[5] ? grant_in_s : ~refused_r);
  // Grant mode: always, executing only, or never
  wire gnt_mode = (gnt_r == OMS_GNT_EN)
                | ((gnt_r == OMS_GNT_RUN) & i_prog_run);
  wire gnt_nxt  = run_nxt & ~mode_r[5] & i_core_grant & gnt_mode;
  // Hit cycles go to the bus only with trace enabled
  wire trc_nxt  = i_bus_cycle & (~i_cache_hit | trc_r);

  // Registered so partner pins see clean levels
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_r   <= 1'b0;
      grant_r <= 1'b0;
      trace_r <= 1'b0;
      brk_r   <= 1'b0;
    end else if (i_clk_en) begin
      run_r   <= run_nxt;
      grant_r <= gnt_nxt;
      trace_r <= trc_nxt;
      brk_r   <= probe_s;
    end
  end

  assign o_run_enable    = run_r;
  assign o_bus_grant_out = grant_r;
  assign o_trace_record  = trace_r;
  assign o_break_master  = brk_r;
  assign o_break_slave   = brk_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence load_mode_s(logic [2:0] m);
    load && clk_mode == m;
  endsequence

  mode0_clock_a: assert property (load_mode_s(OMS_CLK_M0) |=>
    o_phase_lock_a_en && !o_phase_lock_a_shift && o_clock_io_pin_oe
    && o_clock_io_sel_pll_in && !o_use_clock_io) else $error("mode 0 decode");
  mode1_clock_a: assert property (load_mode_s(OMS_CLK_M1) |=>
    o_phase_lock_a_shift && o_clock_io_sel_pll_in) else $error("mode 1 decode");
  mode2_clock_a: assert property (load_mode_s(OMS_CLK_M2) |=>
    o_multiplier_lock_b_en && o_clock_io_pin_oe && !o_clock_io_sel_pll_in)
    else $error("mode 2 decode");
  mode3_clock_a: assert property (load_mode_s(OMS_CLK_M3) |=>
    o_multiplier_lock_b_en && !o_clock_io_pin_oe) else $error("mode 3 decode");
  mode4_clock_a: assert property (load_mode_s(OMS_CLK_M4) |=>
    o_use_clock_io && o_phase_lock_a_en && !o_phase_lock_a_shift)
    else $error("mode 4 decode");
  mode5_clock_a: assert property (load_mode_s(OMS_CLK_M5) |=>
    o_use_clock_io && o_phase_lock_a_shift) else $error("mode 5 decode");
  mode6_clock_a: assert property (load_mode_s(OMS_CLK_M6) |=>
    o_use_clock_io && !o_phase_lock_a_en) else $error("mode 6 decode");
  area_width_a: assert property (load |=>
    o_chip_area_zero_width == $past(sel_word[4:3])) else $error("width");
  master_refuse_a: assert property (load && refuse_nxt |=>
    o_start_refused ##1 !o_run_enable) else $error("master not refused");
  cfg_source_a: assert property (load && src_r == OMS_SRC_CFG |=>
    mode_r == $past(cfg_r)) else $error("config source");
  user_source_a: assert property (load && src_r == OMS_SRC_USER |=>
    mode_r == $past(pins_s)) else $error("user source");
  mix_source_a: assert property (load && src_r == OMS_SRC_MIX |=>
    mode_r[5] == $past(pins_s[5]) && mode_r[4:0] == $past(cfg_r[4:0]))
    else $error("mixed source");
  all_high_a: assert property (load && pins_all_hi && src_r == OMS_SRC_CFG |=>
    !o_start_refused && mode_r == $past(cfg_r)) else $error("all-high pins refused");
  slave_grant_a: assert property ($past(i_clk_en) && o_run_enable
    && o_role_sel |-> $past(grant_in_s)) else $error("slave ran ungranted");
  grant_ctrl_a: assert property ($past(i_clk_en) && o_bus_grant_out |->
    $past(gnt_r) == OMS_GNT_EN || ($past(gnt_r) == OMS_GNT_RUN
    && $past(i_prog_run))) else $error("grant not allowed");
  hit_trace_a: assert property (i_clk_en && i_bus_cycle && i_cache_hit
    |=> o_trace_record == $past(trc_r)) else $error("hit trace");
  both_break_a: assert property (i_clk_en && probe_s |=>
    o_break_master && o_break_slave) else $error("break not shared");
  word_hold_a: assert property (running && !wr_init |=>
    $stable(mode_r) && $stable(clk_r)) else $error("mode word moved");

endmodule

//--- shared/oms_pkg.sv
// Constants and types for the start-up operating mode selector
package oms_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] OMS_CTRL_OFS = 4'h0;  // Control
  localparam logic [3:0] OMS_CFG_OFS  = 4'h4;  // Stored mode word
  localparam logic [3:0] OMS_STAT_OFS = 4'h8;  // Status, read only
  // Control fields
  localparam int OMS_SRC_LSB  = 0;  // Mode source select, 2 bits
  localparam int OMS_GNT_LSB  = 2;  // Grant output control, 2 bits
  localparam int OMS_TRC_BIT  = 4;  // Hit trace control
  localparam int OMS_MUL_LSB  = 5;  // Multiplier factor, 2 bits
  localparam int OMS_INIT_BIT = 8;  // Write one to re-initiate
  // Status fields
  localparam int OMS_PIN_LSB  = 0;  // Live mode pins
  localparam int OMS_ACT_LSB  = 8;  // Active mode word
  localparam int OMS_REF_BIT  = 16; // Master start refused
  localparam int OMS_BAD_BIT  = 17; // Reserved encoding seen
  localparam int OMS_RUN_BIT  = 18; // Pod running
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    OMS_SRC_CFG  = 2'b00,
    OMS_SRC_USER = 2'b01,
    OMS_SRC_MIX  = 2'b10
  } oms_src_t;
  typedef enum logic [1:0] {
    OMS_GNT_EN  = 2'b00,
    OMS_GNT_RUN = 2'b01,
    OMS_GNT_DIS = 2'b10
  } oms_gnt_t;
  typedef enum logic [1:0] {
    OMS_ST_SETTLE = 2'b00,
    OMS_ST_LOAD   = 2'b01,
    OMS_ST_RUN    = 2'b10
  } oms_state_t;
  localparam logic [2:0] OMS_CLK_M0 = 3'h0;
  localparam logic [2:0] OMS_CLK_M1 = 3'h1;
  localparam logic [2:0] OMS_CLK_M2 = 3'h2;
  localparam logic [2:0] OMS_CLK_M3 = 3'h3;
  localparam logic [2:0] OMS_CLK_M4 = 3'h4;
  localparam logic [2:0] OMS_CLK_M5 = 3'h5;
  localparam logic [2:0] OMS_CLK_M6 = 3'h6;
  localparam logic [1:0] OMS_WID_RSV = 2'h3;  // Unused width code
  localparam logic [5:0] OMS_ALL_HIGH = 6'h3f;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [1:0] OMS_MUL_RST = 2'h0;  // Factor 1
  localparam logic [5:0] OMS_CFG_RST = 6'h00;
  localparam logic       OMS_TRC_RST = 1'b1;  // Hit trace on
  localparam logic [1:0] OMS_SETTLE_CYC = 2'h3; // Sync settle time
  localparam logic [1:0] OMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] OMS_RESP_SLVERR = 2'h2;
endpackage

//--- test/oms_board_model.sv
// User board mode pins and second pod, as seen by the selector
`timescale 1ns/10ps
module oms_board_model (
  // Levels asked for by the bench
  input  wire logic [5:0] i_pins_set,
  input  wire logic       i_grant_set,
  input  wire logic       i_break_set,
  // Board side pins
  output logic [5:0]      o_mode_pins,
  output logic            o_grant_in,
  output logic            o_probe_break
);
  // Pins are plain levels; the selector synchronises them itself
  assign o_mode_pins   = i_pins_set;
  // Master pod hands its grant to this slave pod
  assign o_grant_in    = i_grant_set;
  // Shared external probe line
  assign o_probe_break = i_break_set;
endmodule

//--- test/oms_mode_select_tb.sv
// Self-checking bench for the start-up operating mode selector
`timescale 1ns/10ps
`define OMS_CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module oms_mode_select_tb
  import oms_pkg::*;
;
  // ****
  // Stimulus, table and wiring
  // ****
  typedef struct packed {
    logic [1:0] src;
    logic [5:0] cfg;
    logic [5:0] pins;
    logic [5:0] word;
    logic       rfs;
    logic [5:0] clk;
  } oms_tb_row_t;
  // Expected clock field: use_io, lock_a, shift, lock_b, pin drive, pll input
  oms_tb_row_t rows [11] = '{'{2'h0, 6'h00, 6'h00, 6'h00, 1'b0, 6'h13},
    '{2'h0, 6'h09, 6'h00, 6'h09, 1'b0, 6'h1b}, '{2'h0, 6'h12, 6'h00, 6'h12, 1'b0, 6'h06},
    '{2'h1, 6'h00, 6'h03, 6'h03, 1'b0, 6'h04}, '{2'h1, 6'h00, 6'h24, 6'h24, 1'b0, 6'h30},
    '{2'h1, 6'h00, 6'h05, 6'h05, 1'b0, 6'h38}, '{2'h2, 6'h06, 6'h20, 6'h26, 1'b0, 6'h20},
    '{2'h2, 6'h26, 6'h00, 6'h06, 1'b0, 6'h20}, '{2'h0, 6'h0e, 6'h3f, 6'h0e, 1'b0, 6'h20},
    '{2'h0, 6'h0e, 6'h20, 6'h0e, 1'b1, 6'h20},
    '{2'h0, 6'h1f, 6'h00, 6'h1f, 1'b0, 6'h00}};
  logic        clk, rst, en, awv, wv, bre, arv, rre, run, cgnt, bcyc, hit, gnt_set, brk_set;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  rs;
  logic [5:0]  pins_set;
  wire logic   awr, wr, bv, arr, rv, gin, pbrk, use_io, pa_en, pa_sh, pb_en, ck_oe, ck_sel;
  wire logic   role, rfsd, bad, run_en, bgnt, trc, bkm, bks;
  wire logic [1:0]  br, rr, fac, wid;
  wire logic [31:0] rdt;
  wire logic [5:0]  mpins;
  // Clock controls in table order
  wire logic [5:0]  clk_f = {use_io, pa_en, pa_sh, pb_en, ck_oe, ck_sel};
  int          error_cnt;
  int          check_count;
  oms_board_model oms_board_model_inst (.i_pins_set(pins_set), .i_grant_set(gnt_set),
    .i_break_set(brk_set), .o_mode_pins(mpins), .o_grant_in(gin), .o_probe_break(pbrk));
  // Protection fields are held constant
  oms_mode_select oms_mode_select_inst (.i_clock(clk), .i_rst(rst), .i_clk_en(en),
    .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdt),
    .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .i_mode_pins(mpins),
    .i_probe_break(pbrk), .i_grant_in(gin), .i_prog_run(run), .i_core_grant(cgnt),
    .i_bus_cycle(bcyc), .i_cache_hit(hit), .o_use_clock_io(use_io), .o_phase_lock_a_en(pa_en),
    .o_phase_lock_a_shift(pa_sh), .o_multiplier_lock_b_en(pb_en),
    .o_multiplier_lock_b_factor(fac), .o_clock_io_pin_oe(ck_oe), .o_clock_io_sel_pll_in(ck_sel),
    .o_chip_area_zero_width(wid), .o_role_sel(role), .o_start_refused(rfsd), .o_mode_bad(bad),
    .o_run_enable(run_en), .o_bus_grant_out(bgnt), .o_trace_record(trc),
    .o_break_master(bkm), .o_break_slave(bks));
  // The user side supplies the only clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A handshake that never completes ends the run
  task automatic tmo();
    error_cnt++;
    $display("[FAIL] handshake exp 1 got 0");
    end_of_test();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    rs = br;
    bre <= 1'b0;
    if (n >= 50) tmo();
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    rd = rdt;
    rs = rr;
    rre <= 1'b0;
    if (n >= 50) tmo();
  endtask
  // Reset with safe pins, program, then re-initiate; pins held through load
  task automatic setup(input logic [1:0] s, input logic [5:0] c, input logic [5:0] p);
    pins_set <= 6'h00;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    axi_wr(OMS_CFG_OFS, {26'h0, c});
    axi_wr(OMS_CTRL_OFS, {30'h0, s} | 32'h10);
    pins_set <= p;
    repeat (6) @(posedge clk);
    axi_wr(OMS_CTRL_OFS, {30'h0, s} | 32'h110);
    repeat (8) @(posedge clk);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {awv, wv, bre, arv, rre, run, cgnt, bcyc, hit, brk_set} = '0;
    {awa, ara, wd, pins_set} = '0;
    {gnt_set, en} = 2'b11;
    rst = 1'b1;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    axi_rd(OMS_CTRL_OFS);
    `OMS_CHK("ctrl", 32'h10, rd)
    axi_rd(4'hc);
    `OMS_CHK("unmapped", OMS_RESP_SLVERR, rs)
    axi_wr(4'hc, 32'h0);
    `OMS_CHK("unmapped wr", OMS_RESP_SLVERR, rs)
    $display("reset test done");
    foreach (rows[k]) begin
      setup(rows[k].src, rows[k].cfg, rows[k].pins);
      axi_rd(OMS_STAT_OFS);
      `OMS_CHK("word", rows[k].word, rd[13:8])
      `OMS_CHK("refused", rows[k].rfs, rd[16])
      `OMS_CHK("pins", rows[k].pins, rd[5:0])
      `OMS_CHK("clock", rows[k].clk, clk_f)
      `OMS_CHK("bad", {2{rows[k].word[2:0] > OMS_CLK_M6 || rows[k].word[4:3] == OMS_WID_RSV}}, {bad, rd[17]})
      `OMS_CHK("width", rows[k].word[4:3], wid)
      `OMS_CHK("role", rows[k].word[5], role)
      `OMS_CHK("run", ~rows[k].rfs, run_en)
      $display("row %0d done", k);
    end
    // Pins moved after load must not reach the active word
    setup(OMS_SRC_CFG, 6'h00, 6'h00);
    pins_set <= 6'h2a;
    repeat (6) @(posedge clk);
    axi_rd(OMS_STAT_OFS);
    `OMS_CHK("held", 6'h00, rd[13:8])
    `OMS_CHK("live", 6'h2a, rd[5:0])
    cgnt <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      for (int r = 0; r < 2; r++) begin
        axi_wr(OMS_CTRL_OFS, (g << 2) | 32'h10);
        run <= r[0];
        repeat (4) @(posedge clk);
        `OMS_CHK("grant", 1'((g == 0) || (g == 1 && r == 1)), bgnt)
      end
    end
    bcyc <= 1'b1;
    hit <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      axi_wr(OMS_CTRL_OFS, (t << 4) | 32'h40);
      repeat (3) @(posedge clk);
      `OMS_CHK("trace", t[0], trc)
      `OMS_CHK("factor", 2'h2, fac)
    end
    // A frozen block must not pass the break on
    en <= 1'b0;
    brk_set <= 1'b1;
    repeat (5) @(posedge clk);
    `OMS_CHK("frozen", 2'b00, {bkm, bks})
    en <= 1'b1;
    repeat (5) @(posedge clk);
    `OMS_CHK("break", 2'b11, {bkm, bks})
    brk_set <= 1'b0;
    // A slave that loses the master's grant must stop
    setup(OMS_SRC_USER, 6'h00, 6'h24);
    gnt_set <= 1'b0;
    repeat (5) @(posedge clk);
    `OMS_CHK("slave run", 1'b0, run_en)
    $display("awkward tests done");
    end_of_test();
  end
endmodule
